/* File: core/spcg_pkg.sv */
// Purpose: shared constants and types of the sleep-mode port clock gating
// Assumes: 32-bit register bus with full byte addresses
// Notes:   offsets are relative to the system control base
package spcg_pkg;

	localparam int unsigned NUM_PORTS   = 8;
	localparam int unsigned IDX_W       = 3;

	localparam logic [31:0] SYSCTL_BASE = 32'h400F_E000;

	localparam logic [11:0] OFS_SLEEP_GATE  = 12'h118;
	localparam logic [11:0] OFS_FAULT_INFO  = 12'h1EC;
	localparam logic [11:0] OFS_CTRL        = 12'h1F0;
	localparam logic [11:0] OFS_IRQ_STATUS  = 12'h1F4;
	localparam logic [11:0] OFS_IRQ_MASK    = 12'h1F8;
	localparam logic [11:0] OFS_GATE_STATE  = 12'h1FC;

	localparam logic [7:0]  SLEEP_GATE_RST  = 8'h00;
	localparam logic [7:0]  IRQ_MASK_RST    = 8'h00;
	localparam logic [7:0]  IRQ_STATUS_RST  = 8'h00;
	localparam logic        ACG_RST         = 1'b0;
	localparam logic [7:0]  FAULT_CNT_RST   = 8'h00;
	localparam logic [31:0] RDATA_RST       = 32'h0000_0000;

	localparam int unsigned CTRL_ACG_BIT    = 0;
	localparam int unsigned FINFO_IDX_LSB   = 0;
	localparam int unsigned FINFO_WR_BIT    = 3;
	localparam int unsigned FINFO_SEEN_BIT  = 4;
	localparam int unsigned FINFO_CNT_LSB   = 8;

	typedef enum logic [1:0] {
		PM_RUN,
		PM_SLEEP,
		PM_DEEP
	} spcg_pmode_t;

endpackage

/* File: core/spcg_port_gate.sv */
// Purpose: clock enable and access check for one port unit
// Assumes: pmode and the gate bits are synchronous to core_clk
// Notes:   clk_en feeds an external clock gate cell
`timescale 1ns/1ps
module spcg_port_gate (
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	input  wire spcg_pkg::spcg_pmode_t pmode,
	input  wire logic                 acg_sel,
	input  wire logic                 run_gate,
	input  wire logic                 sleep_gate,
	input  wire logic                 deep_gate,
	input  wire logic                 acc,
	output logic                      clk_en,
	output logic                      fault
);
	import spcg_pkg::*;

	typedef struct packed {
		logic clk_en;
	} spcg_gate_state_t;

	spcg_gate_state_t state_reg;
	spcg_gate_state_t state_next;
	logic             sel;

	always_comb begin
		state_next = state_reg;
		sel        = run_gate;
		// without auto gating the run setting holds in every mode
		if (acg_sel) begin
			case (pmode)
				PM_SLEEP: sel = sleep_gate;
				PM_DEEP:  sel = deep_gate;
				default:  sel = run_gate;
			endcase
		end
		state_next.clk_en = sel;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign clk_en = state_reg.clk_en;
	// checked against the enable actually applied, not the pending one
	assign fault  = acc & ~state_reg.clk_en;

endmodule

/* File: core/spcg_top.sv */
// Purpose: sleep-mode port clock gating register bank and fault check
// Assumes: one clock, synchronous reset, single-cycle register strobes
// Notes:   run and deep-sleep gate words come from sibling registers
//
// Behaviour
// - bits 7..0 clock ports H..A when set
// - access to unclocked port answers bus fault
// - reset clears register, all ports unclocked
// - bits 31..8 reserved, read as zero
// - settings apply while system is in sleep
// - effective only with auto gating selected
// - decoded at base plus offset 0x118
`timescale 1ns/1ps
module spcg_top (
	input  wire logic                 core_clk,
	input  wire logic                 sys_rst,
	input  wire logic [31:0]          bus_addr,
	input  wire logic [31:0]          bus_wdata,
	input  wire logic                 bus_wr,
	input  wire logic                 bus_rd,
	output logic [31:0]               bus_rdata,
	input  wire spcg_pkg::spcg_pmode_t pmode,
	input  wire logic [7:0]           run_port_clock_gate,
	input  wire logic [7:0]           deep_sleep_port_clock_gate,
	input  wire logic                 port_acc_valid,
	input  wire logic [2:0]           port_acc_idx,
	input  wire logic                 port_acc_write,
	output logic [7:0]                port_clk_en,
	output logic                      bus_fault,
	output logic                      irq
);
	import spcg_pkg::*;

	typedef struct packed {
		logic [7:0]  sleep_gate;
		logic        auto_gating_select;
		logic [7:0]  irq_status;
		logic [7:0]  irq_mask;
		logic [2:0]  fault_idx;
		logic        fault_write;
		logic        fault_seen;
		logic [7:0]  fault_cnt;
		logic [31:0] rdata;
	} spcg_state_t;

	spcg_state_t state_reg;
	spcg_state_t state_next;

	logic [7:0]  acc_vec;
	logic [7:0]  fault_vec;
	logic        fault_any;
	logic        hit_sleep;
	logic        hit_ctrl;
	logic        hit_status;
	logic        hit_mask;
	logic        hit_state;
	logic        hit_finfo;
	logic [31:0] rd_word;

	// full byte address compare against base plus offset
	function automatic logic reg_hit(
		input logic [31:0] addr,
		input logic [11:0] ofs
	);
		logic [31:0] full;
		full    = SYSCTL_BASE + {20'h0_0000, ofs};
		reg_hit = (addr == full);
	endfunction

	function automatic logic [7:0] idx_onehot(
		input logic [2:0] idx
	);
		logic [7:0] v;
		v      = 8'h00;
		v[idx] = 1'b1;
		idx_onehot = v;
	endfunction

	function automatic logic [31:0] pad8(
		input logic [7:0] v
	);
		pad8 = {24'h00_0000, v};
	endfunction

	assign hit_sleep  = reg_hit(bus_addr, OFS_SLEEP_GATE);
	assign hit_ctrl   = reg_hit(bus_addr, OFS_CTRL);
	assign hit_status = reg_hit(bus_addr, OFS_IRQ_STATUS);
	assign hit_mask   = reg_hit(bus_addr, OFS_IRQ_MASK);
	assign hit_state  = reg_hit(bus_addr, OFS_GATE_STATE);
	assign hit_finfo  = reg_hit(bus_addr, OFS_FAULT_INFO);

	assign acc_vec = port_acc_valid ? idx_onehot(port_acc_idx) : 8'h00;

	generate
		for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
			spcg_port_gate u_gate (
				.core_clk   (core_clk),
				.sys_rst    (sys_rst),
				.pmode      (pmode),
				.acg_sel    (state_reg.auto_gating_select),
				.run_gate   (run_port_clock_gate[p]),
				.sleep_gate (state_reg.sleep_gate[p]),
				.deep_gate  (deep_sleep_port_clock_gate[p]),
				.acc        (acc_vec[p]),
				.clk_en     (port_clk_en[p]),
				.fault      (fault_vec[p])
			);
		end
	endgenerate

	assign fault_any = |fault_vec;

	// read mux; unmapped addresses and reserved bits read as zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (hit_sleep) begin
			rd_word = pad8(state_reg.sleep_gate);
		end else if (hit_ctrl) begin
			rd_word[CTRL_ACG_BIT] = state_reg.auto_gating_select;
		end else if (hit_status) begin
			rd_word = pad8(state_reg.irq_status);
		end else if (hit_mask) begin
			rd_word = pad8(state_reg.irq_mask);
		end else if (hit_state) begin
			rd_word = pad8(port_clk_en);
		end else if (hit_finfo) begin
			rd_word[FINFO_IDX_LSB +: 3]   = state_reg.fault_idx;
			rd_word[FINFO_WR_BIT]         = state_reg.fault_write;
			rd_word[FINFO_SEEN_BIT]       = state_reg.fault_seen;
			rd_word[FINFO_CNT_LSB +: 8]   = state_reg.fault_cnt;
		end
	end

	always_comb begin
		state_next = state_reg;

		// read data stand only in the cycle after the strobe
		state_next.rdata = bus_rd ? rd_word : RDATA_RST;

		if (bus_wr) begin
			if (hit_sleep) begin
				// only the low byte is writable; upper bits are dropped
				state_next.sleep_gate = bus_wdata[7:0];
			end
			if (hit_ctrl) begin
				state_next.auto_gating_select = bus_wdata[CTRL_ACG_BIT];
			end
			if (hit_mask) begin
				state_next.irq_mask = bus_wdata[7:0];
			end
			if (hit_finfo) begin
				// any write rearms the capture and zeroes the count
				state_next.fault_seen = 1'b0;
				state_next.fault_cnt  = FAULT_CNT_RST;
			end
		end

		// status clears on read, but a fault in that cycle survives
		if (bus_rd && hit_status) begin
			state_next.irq_status = IRQ_STATUS_RST;
		end
		state_next.irq_status = state_next.irq_status | fault_vec;

		if (fault_any) begin
			// first fault since rearm is kept for software to inspect
			if (!state_next.fault_seen) begin
				state_next.fault_idx   = port_acc_idx;
				state_next.fault_write = port_acc_write;
				state_next.fault_seen  = 1'b1;
			end
			// saturating so a storm cannot wrap to a small count
			if (state_next.fault_cnt != 8'hFF) begin
				state_next.fault_cnt = state_next.fault_cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_reg.sleep_gate  <= SLEEP_GATE_RST;
			state_reg.auto_gating_select         <= ACG_RST;
			state_reg.irq_status  <= IRQ_STATUS_RST;
			state_reg.irq_mask    <= IRQ_MASK_RST;
			state_reg.fault_idx   <= 3'h0;
			state_reg.fault_write <= 1'b0;
			state_reg.fault_seen  <= 1'b0;
			state_reg.fault_cnt   <= FAULT_CNT_RST;
			state_reg.rdata       <= RDATA_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign bus_rdata = state_reg.rdata;
	// the requester sees the fault in the cycle of its access
	assign bus_fault = fault_any;
	assign irq       = |(state_reg.irq_status & state_reg.irq_mask);

endmodule

/* File: testbench/spcg_assertions.sv */
// Purpose: port checks of the sleep port gating bank
// Assumes: control state is shadowed from bus writes
// Notes:   bound into spcg_top
`timescale 1ns/1ps
module spcg_assertions (
	input wire logic                  core_clk,
	input wire logic                  sys_rst,
	input wire logic [31:0]           bus_addr,
	input wire logic [31:0]           bus_wdata,
	input wire logic                  bus_wr,
	input wire logic                  bus_rd,
	input wire logic [31:0]           bus_rdata,
	input wire spcg_pkg::spcg_pmode_t pmode,
	input wire logic [7:0]            run_port_clock_gate,
	input wire logic [7:0]            deep_sleep_port_clock_gate,
	input wire logic                  port_acc_valid,
	input wire logic [2:0]            port_acc_idx,
	input wire logic [7:0]            port_clk_en,
	input wire logic                  bus_fault,
	input wire logic                  irq
);
	import spcg_pkg::*;
	localparam logic [31:0] A_SG = SYSCTL_BASE + {20'h0, OFS_SLEEP_GATE};
	localparam logic [31:0] A_CT = SYSCTL_BASE + {20'h0, OFS_CTRL};
	localparam logic [31:0] A_MK = SYSCTL_BASE + {20'h0, OFS_IRQ_MASK};
	logic [7:0] sg_reg;
	logic [7:0] mk_reg;
	logic       acg_reg;
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sg_reg <= 8'h00;
			mk_reg <= 8'h00;
			acg_reg <= 1'b0;
		end else if (bus_wr) begin
			if (bus_addr == A_SG) sg_reg <= bus_wdata[7:0];
			if (bus_addr == A_MK) mk_reg <= bus_wdata[7:0];
			if (bus_addr == A_CT) acg_reg <= bus_wdata[0];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	fault_match_a: assert property (port_acc_valid |->
		bus_fault == !port_clk_en[port_acc_idx]) else $error("fault wrong");
	rst_gated_a: assert property ($past(sys_rst) |->
		port_clk_en == 8'h00) else $error("enable after reset");
	rsvd_zero_a: assert property ($past(bus_rd) && $past(bus_addr) == A_SG
		|-> bus_rdata[31:8] == 24'h0) else $error("reserved bits set");
	gate_read_a: assert property ($past(bus_rd) && $past(bus_addr) == A_SG
		|-> bus_rdata[7:0] == $past(sg_reg)) else $error("gate read wrong");
	sleep_sel_a: assert property (acg_reg && pmode == PM_SLEEP |=>
		port_clk_en == $past(sg_reg)) else $error("sleep enable wrong");
	deep_sel_a: assert property (acg_reg && pmode == PM_DEEP |=>
		port_clk_en == $past(deep_sleep_port_clock_gate)) else $error("deep");
	run_sel_a: assert property (!acg_reg || pmode == PM_RUN |=>
		port_clk_en == $past(run_port_clock_gate)) else $error("run wrong");
	fault_irq_a: assert property (bus_fault && mk_reg[port_acc_idx] |=>
		irq) else $error("no interrupt");
endmodule
bind spcg_top spcg_assertions u_chk (.core_clk, .sys_rst, .bus_addr,
	.bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .pmode, .run_port_clock_gate,
	.deep_sleep_port_clock_gate, .port_acc_valid, .port_acc_idx,
	.port_clk_en, .bus_fault, .irq);

/* File: testbench/tb_spcg_top.sv */
// Purpose: random and directed test of the sleep port gating bank
// Assumes: one-cycle strobes, read data one cycle later
// Notes:   expected fault bits are tracked in st
`timescale 1ns/1ps
module tb_spcg_top;
	import spcg_pkg::*;
	localparam logic [31:0] A_SG = SYSCTL_BASE + {20'h0, OFS_SLEEP_GATE};
	localparam logic [31:0] A_CT = SYSCTL_BASE + {20'h0, OFS_CTRL};
	localparam logic [31:0] A_MK = SYSCTL_BASE + {20'h0, OFS_IRQ_MASK};
	localparam logic [31:0] A_ST = SYSCTL_BASE + {20'h0, OFS_IRQ_STATUS};
	localparam logic [31:0] A_GS = SYSCTL_BASE + {20'h0, OFS_GATE_STATE};
	localparam logic [31:0] A_FI = SYSCTL_BASE + {20'h0, OFS_FAULT_INFO};
	logic core_clk = 1'b0, sys_rst = 1'b1, bus_wr = 1'b0, bus_rd = 1'b0;
	logic port_acc_valid = 1'b0, port_acc_write = 1'b0, bus_fault, irq;
	logic [31:0] bus_addr = 32'h0, bus_wdata = 32'h0, bus_rdata;
	logic [7:0] run_w = 8'h00, deep_w = 8'h00, st = 8'h00, port_clk_en, v;
	logic [2:0] port_acc_idx = 3'h0;
	spcg_pmode_t pmode = PM_RUN;
	int err_count = 0, n_compared = 0;
	// first fault since rearm and the fault count, as software should see
	logic [2:0] f_idx = 3'h0;
	logic f_wr = 1'b0, f_seen = 1'b0;
	logic [7:0] f_cnt = 8'h00;
	spcg_top dut (.core_clk, .sys_rst, .bus_addr, .bus_wdata, .bus_wr,
		.bus_rd, .bus_rdata, .pmode, .run_port_clock_gate(run_w),
		.deep_sleep_port_clock_gate(deep_w), .port_acc_valid,
		.port_acc_idx, .port_acc_write, .port_clk_en, .bus_fault, .irq);
	always #2.5 core_clk = ~core_clk;
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(logic [31:0] a, logic [31:0] d);
		@(posedge core_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge core_clk);
		bus_wr <= 1'b0;
	endtask
	task automatic rd(logic [31:0] a, logic [31:0] e);
		@(posedge core_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		#1 chk("rdata", e, bus_rdata);
	endtask
	task automatic acc(logic [2:0] i, logic e);
		logic w;
		w = 1'($urandom);
		@(posedge core_clk);
		port_acc_valid <= 1'b1;
		port_acc_idx <= i;
		port_acc_write <= w;
		#1 chk("fault", 32'(e), 32'(bus_fault));
		if (e && !f_seen) begin
			f_idx = i;
			f_wr = w;
		end
		if (e) f_seen = 1'b1;
		if (e && f_cnt != 8'hFF) f_cnt++;
		if (e) st[i] = 1'b1;
		@(posedge core_clk);
		port_acc_valid <= 1'b0;
	endtask
	task automatic mode(spcg_pmode_t m, logic [7:0] e);
		@(posedge core_clk);
		pmode <= m;
		repeat (2) @(posedge core_clk);
		#1 chk("clk_en", 32'(e), 32'(port_clk_en));
	endtask
	// gate word that should reach the ports for a given selector and mode
	function automatic logic [7:0] exp_en(logic a, spcg_pmode_t m,
		logic [7:0] s);
		exp_en = run_w;
		if (a && m == PM_SLEEP) exp_en = s;
		if (a && m == PM_DEEP) exp_en = deep_w;
	endfunction
	function automatic logic [31:0] finfo(logic [2:0] i, logic w, logic s,
		logic [7:0] c);
		finfo = 32'h0000_0000;
		finfo[FINFO_IDX_LSB +: 3] = i;
		finfo[FINFO_WR_BIT] = w;
		finfo[FINFO_SEEN_BIT] = s;
		finfo[FINFO_CNT_LSB +: 8] = c;
	endfunction
	task automatic final_report;
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#40000;
		err_count++;
		final_report;
	end
	initial begin
		void'($urandom(68));
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(A_SG, 32'h0);
		acc(3'h5, 1'b1);
		wr(A_CT, 32'h1);
		for (int k = 0; k < 8; k++) begin
			v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
			run_w <= 8'($urandom);
			deep_w <= 8'($urandom);
			wr(A_SG, {24'($urandom), v});
			mode(PM_SLEEP, exp_en(1'b1, PM_SLEEP, v));
			rd(A_SG, 32'(v));
			rd(A_GS, 32'(v));
			for (int i = 0; i < 8; i++) acc(3'(i), !v[i]);
			mode(PM_DEEP, exp_en(1'b1, PM_DEEP, v));
			mode(PM_RUN, exp_en(1'b1, PM_RUN, v));
		end
		wr(A_CT, 32'h0);
		mode(PM_SLEEP, exp_en(1'b0, PM_SLEEP, v));
		wr(A_SG + 32'h4, 32'hFF);
		wr(32'h400F_F118, 32'hFF);
		rd(A_SG, 32'(v));
		rd(A_SG + 32'h4, 32'h0);
		run_w <= 8'h00;
		rd(A_ST, 32'(st));
		st = 8'h00;
		wr(A_FI, 32'h0);
		f_seen = 1'b0;
		f_cnt = 8'h00;
		wr(A_MK, 32'h4);
		acc(3'h3, 1'b1);
		#1 chk("irq", 32'h0, 32'(irq));
		acc(3'h2, 1'b1);
		#1 chk("irq", 32'h1, 32'(irq));
		rd(A_FI, finfo(f_idx, f_wr, f_seen, f_cnt));
		rd(A_ST, 32'(st));
		chk("irq", 32'h0, 32'(irq));
		// a fault in the very cycle of the clearing read must survive
		fork
			rd(A_ST, 32'h0);
			acc(3'h6, 1'b1);
		join
		rd(A_ST, 32'h40);
		@(posedge core_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(A_SG, 32'h0);
		rd(A_GS, 32'h0);
		final_report;
	end
endmodule
